// [verilog/sequencer_pkg.sv]
// shared constants for the regulator setpoint and enable sequencer
package sequencer_pkg;

  // byte offsets of the register map
  localparam logic [7:0] REGULATOR_A_CONTROL_OFFSET       = 8'h02;
  localparam logic [7:0] REGULATOR_B_CONTROL_OFFSET       = 8'h04;
  localparam logic [7:0] REGULATOR_A_SETPOINT_OFFSET      = 8'h06;
  localparam logic [7:0] REGULATOR_B_SETPOINT_OFFSET      = 8'h07;
  localparam logic [7:0] REGULATOR_A_DELAYS_OFFSET        = 8'h0C;
  localparam logic [7:0] REGULATOR_B_DELAYS_OFFSET        = 8'h0D;
  localparam logic [7:0] GENERAL_OUTPUT_A_DELAYS_OFFSET   = 8'h10;
  localparam logic [7:0] GENERAL_OUTPUT_B_DELAYS_OFFSET   = 8'h11;
  localparam logic [7:0] GENERAL_OUTPUT_CONTROL_OFFSET    = 8'h12;
  localparam logic [7:0] CONFIGURATION_OFFSET             = 8'h13;
  localparam logic [7:0] SEQUENCE_STATUS_OFFSET           = 8'h1F;

  // field positions
  localparam int REG_ENABLE_BIT        = 0;
  localparam int REG_PIN_GATING_BIT    = 1;
  localparam int GPO_A_LEVEL_BIT       = 0;
  localparam int GPO_A_PIN_GATING_BIT  = 1;
  localparam int GPO_B_LEVEL_BIT       = 4;
  localparam int GPO_B_PIN_GATING_BIT  = 5;
  localparam int STARTUP_RANGE_BIT     = 6;
  localparam int SHUTDOWN_RANGE_BIT    = 5;
  localparam int TURNON_FIELD_LSB      = 0;
  localparam int TURNOFF_FIELD_LSB     = 4;
  localparam int DELAY_FIELD_WIDTH     = 4;

  // reset values of the stored registers
  localparam logic [7:0] CONTROL_RESET  = 8'h00;
  localparam logic [7:0] SETPOINT_RESET = 8'h00;
  localparam logic [7:0] DELAYS_RESET   = 8'h00;
  localparam logic [7:0] CONFIG_RESET   = 8'h00;

  // setpoint code ranges and voltage mapping, in millivolts
  localparam logic [7:0]  SETPOINT_FIRST_VALID = 8'h4C;
  localparam logic [7:0]  SETPOINT_FINE_LAST   = 8'h9D;
  localparam logic [7:0]  SETPOINT_COARSE_BASE = 8'h9E;
  localparam logic [11:0] FINE_BASE_MV         = 12'h3E8;
  localparam logic [11:0] FINE_STEP_MV         = 12'h005;
  localparam logic [11:0] COARSE_BASE_MV       = 12'h58C;
  localparam logic [11:0] COARSE_STEP_MV       = 12'h014;

  // delay time base: one step of the short range
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int DELAY_STEP_NS   = 500000;
  localparam int DELAY_STEP_CYCLES = DELAY_STEP_NS / CLOCK_PERIOD_NS;

endpackage : sequencer_pkg

// [verilog/sequence_delay_channel.sv]
// one delayed follower of the enable pin, restartable on every edge
`timescale 1ns/1ps
module sequence_delay_channel
  import sequencer_pkg::*;
#(
  parameter int STEP_CYCLES = DELAY_STEP_CYCLES
) (
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  input  wire logic       pin_level_in,
  input  wire logic       pin_edge_in,
  input  wire logic [3:0] delay_code_in,
  input  wire logic       long_range_in,
  output logic            level_out,
  output logic            busy_out
);

  typedef enum logic {IDLE, COUNTING} channel_state_t;

  localparam int CW = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
  localparam logic [CW-1:0] LAST_CYCLE = CW'(STEP_CYCLES - 1);

  channel_state_t  state;
  logic [CW-1:0]   cycle_cnt;
  logic [4:0]      steps_left;
  logic            pending_level;
  wire  logic [4:0] step_target;
  wire  logic       step_done;

  // long range doubles the count of half-millisecond steps
  assign step_target = long_range_in ? {delay_code_in, 1'b0}  // [R15] [R16]
                                     : {1'b0, delay_code_in}; // [R14]
  assign step_done   = (cycle_cnt == LAST_CYCLE);
  assign busy_out    = (state == COUNTING);

  // a new edge always wins, so a pending delay is dropped and retimed
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state         <= IDLE;
      cycle_cnt     <= '0;
      steps_left    <= 5'h00;
      pending_level <= 1'b0;
      level_out     <= 1'b0;
    end else if (pin_edge_in) begin                         // [R20]
      cycle_cnt     <= '0;
      steps_left    <= step_target;
      pending_level <= pin_level_in;
      if (step_target == 5'h00) begin
        level_out <= pin_level_in;                          // [R14]
        state     <= IDLE;
      end else begin
        state <= COUNTING;
      end
    end else if (state == COUNTING) begin
      // the prescaler restarts per edge, so no phase error on the step
      cycle_cnt <= step_done ? '0 : cycle_cnt + 1'b1;       // [R21]
      if (step_done) begin
        if (steps_left == 5'h01) begin
          level_out <= pending_level;
          state     <= IDLE;
        end
        steps_left <= steps_left - 5'h01;
      end
    end
  end

endmodule // sequence_delay_channel

// [verilog/regulator_setpoint_and_enable_sequencer.sv]
// register file, setpoint mapping and enable sequencing of two regulators
//
// Functional notes
// R1: codes below 0x4C are reserved; device maps them to zero millivolts.
// R2: codes 0x4C to 0x9D give 1 V to 1.405 V in 5 mV steps.
// R3: codes 0x9E to 0xFF give 1.42 V to 3.36 V in 20 mV steps.
// R4: regulator A has an 8-bit read-write setpoint register.
// R5: regulator B has its own setpoint register with identical mapping.
// R6: regulator A turns on after its turn-on delay from pin rise.
// R7: regulator A turns off after its turn-off delay from pin fall.
// R8: regulator B turns on after its turn-on delay from pin rise.
// R9: regulator B turns off after its turn-off delay from pin fall.
// R10: general output A rises after its rise delay from pin rise.
// R11: general output A falls after its fall delay from pin fall.
// R12: general output B rises after its rise delay from pin rise.
// R13: general output B falls after its fall delay from pin fall.
// R14: short range: code N gives N times 0.5 ms, zero is immediate.
// R15: startup range bit set gives 1 ms steps, up to 15 ms.
// R16: shutdown range bit set gives 1 ms steps, up to 15 ms.
// R17: configuration bit 6 selects startup range for all channels.
// R18: configuration bit 5 selects shutdown range for all channels.
// R19: with pin gating set, output needs enable bit and delayed pin.
// R20: an edge during a pending delay restarts timing from that edge.
// R21: delay timers count from a time base exact to 0.5 ms.
`timescale 1ns/1ps
module regulator_setpoint_and_enable_sequencer
  import sequencer_pkg::*;
#(
  parameter int STEP_CYCLES = DELAY_STEP_CYCLES
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  input  wire logic        enable_pin_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output logic      [7:0]  reg_rdata_out,
  output logic             regulator_a_on_out,
  output logic             regulator_b_on_out,
  output logic             general_output_a_out,
  output logic             general_output_b_out,
  output logic      [7:0]  regulator_a_setpoint_code_out,
  output logic      [7:0]  regulator_b_setpoint_code_out,
  output logic      [11:0] regulator_a_target_mv_out,
  output logic      [11:0] regulator_b_target_mv_out
);

  // channel slots; the status word packs busy flags in this order
  localparam int CHANNELS = 4;
  localparam int CH_REG_A = 0;
  localparam int CH_REG_B = 1;
  localparam int CH_GPO_A = 2;
  localparam int CH_GPO_B = 3;

  // stored registers
  logic [7:0] regulator_a_control;
  logic [7:0] regulator_b_control;
  logic [7:0] regulator_a_voltage_setpoint;
  logic [7:0] regulator_b_voltage_setpoint;
  logic [7:0] regulator_a_sequence_delays;
  logic [7:0] regulator_b_sequence_delays;
  logic [7:0] general_output_a_sequence_delays;
  logic [7:0] general_output_b_sequence_delays;
  logic [7:0] general_output_control;
  logic [7:0] configuration;

  // enable pin edge detection
  logic       pin_q;
  wire  logic pin_edge;

  // channel wiring
  wire  logic [7:0] channel_delays [CHANNELS];
  wire  logic [3:0] channel_code   [CHANNELS];
  wire  logic [CHANNELS-1:0] channel_level;
  wire  logic [CHANNELS-1:0] channel_busy;

  // decode and register read mux
  wire  logic       hit_reg_a_ctrl;
  wire  logic       hit_reg_b_ctrl;
  wire  logic       hit_reg_a_set;
  wire  logic       hit_reg_b_set;
  wire  logic       hit_reg_a_dly;
  wire  logic       hit_reg_b_dly;
  wire  logic       hit_gpo_a_dly;
  wire  logic       hit_gpo_b_dly;
  wire  logic       hit_gpo_ctrl;
  wire  logic       hit_config;
  wire  logic       hit_status;
  wire  logic [7:0] status_word;
  wire  logic [7:0] next_rdata;

  // range select and gated output terms
  wire  logic startup_long;
  wire  logic shutdown_long;
  wire  logic active_long;
  wire  logic [11:0] regulator_a_target_mv;
  wire  logic [11:0] regulator_b_target_mv;
  wire  logic next_regulator_a_on;
  wire  logic next_regulator_b_on;
  wire  logic next_general_output_a;
  wire  logic next_general_output_b;

  // setpoint to millivolt mapping, shared by both regulators
  function automatic logic [11:0] setpoint_to_mv(input logic [7:0] code);
    logic [11:0] fine_offset;
    logic [11:0] coarse_offset;
    // both offsets are formed up front; only the matching one is used
    fine_offset   = {4'h0, code - SETPOINT_FIRST_VALID};
    coarse_offset = {4'h0, code - SETPOINT_COARSE_BASE};
    if (code < SETPOINT_FIRST_VALID) begin
      setpoint_to_mv = 12'h000;                                   // [R1]
    end else if (code <= SETPOINT_FINE_LAST) begin
      setpoint_to_mv = FINE_BASE_MV + 12'(fine_offset * FINE_STEP_MV); // [R2]
    end else begin
      setpoint_to_mv = COARSE_BASE_MV
                     + 12'(coarse_offset * COARSE_STEP_MV);       // [R3]
    end
  endfunction

  // address decode
  assign hit_reg_a_ctrl = (reg_addr_in == REGULATOR_A_CONTROL_OFFSET);
  assign hit_reg_b_ctrl = (reg_addr_in == REGULATOR_B_CONTROL_OFFSET);
  assign hit_reg_a_set  = (reg_addr_in == REGULATOR_A_SETPOINT_OFFSET);
  assign hit_reg_b_set  = (reg_addr_in == REGULATOR_B_SETPOINT_OFFSET);
  assign hit_reg_a_dly  = (reg_addr_in == REGULATOR_A_DELAYS_OFFSET);
  assign hit_reg_b_dly  = (reg_addr_in == REGULATOR_B_DELAYS_OFFSET);
  assign hit_gpo_a_dly  = (reg_addr_in == GENERAL_OUTPUT_A_DELAYS_OFFSET);
  assign hit_gpo_b_dly  = (reg_addr_in == GENERAL_OUTPUT_B_DELAYS_OFFSET);
  assign hit_gpo_ctrl   = (reg_addr_in == GENERAL_OUTPUT_CONTROL_OFFSET);
  assign hit_config     = (reg_addr_in == CONFIGURATION_OFFSET);
  assign hit_status     = (reg_addr_in == SEQUENCE_STATUS_OFFSET);

  // live sequencing state: busy timers in the high nibble, levels low
  // busy bits show a delay still counting, useful before a re-trigger
  assign status_word = {channel_busy, general_output_b_out,
                        general_output_a_out, regulator_b_on_out,
                        regulator_a_on_out};

  // unmapped offsets read as zero
  assign next_rdata =
      hit_reg_a_ctrl ? regulator_a_control :
      hit_reg_b_ctrl ? regulator_b_control :
      hit_reg_a_set  ? regulator_a_voltage_setpoint :
      hit_reg_b_set  ? regulator_b_voltage_setpoint :
      hit_reg_a_dly  ? regulator_a_sequence_delays :
      hit_reg_b_dly  ? regulator_b_sequence_delays :
      hit_gpo_a_dly  ? general_output_a_sequence_delays :
      hit_gpo_b_dly  ? general_output_b_sequence_delays :
      hit_gpo_ctrl   ? general_output_control :
      hit_config     ? configuration :
      hit_status     ? status_word : 8'h00;

  // control writes; unimplemented bits are dropped and read back zero
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      regulator_a_control    <= CONTROL_RESET;
      regulator_b_control    <= CONTROL_RESET;
      general_output_control <= CONTROL_RESET;
      configuration          <= CONFIG_RESET;
    end else if (reg_write_in) begin
      if (hit_reg_a_ctrl) regulator_a_control <= reg_wdata_in & 8'h03;
      if (hit_reg_b_ctrl) regulator_b_control <= reg_wdata_in & 8'h03;
      if (hit_gpo_ctrl)   general_output_control <= reg_wdata_in & 8'h33;
      if (hit_config)     configuration <= reg_wdata_in & 8'h60;
    end
  end

  // setpoint and delay writes; a reserved setpoint code is stored as
  // written, the host is expected not to use it
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      regulator_a_voltage_setpoint     <= SETPOINT_RESET;
      regulator_b_voltage_setpoint     <= SETPOINT_RESET;
      regulator_a_sequence_delays      <= DELAYS_RESET;
      regulator_b_sequence_delays      <= DELAYS_RESET;
      general_output_a_sequence_delays <= DELAYS_RESET;
      general_output_b_sequence_delays <= DELAYS_RESET;
    end else if (reg_write_in) begin
      if (hit_reg_a_set)  regulator_a_voltage_setpoint <= reg_wdata_in; // [R4]
      if (hit_reg_b_set)  regulator_b_voltage_setpoint <= reg_wdata_in; // [R5]
      if (hit_reg_a_dly)  regulator_a_sequence_delays <= reg_wdata_in;
      if (hit_reg_b_dly)  regulator_b_sequence_delays <= reg_wdata_in;
      if (hit_gpo_a_dly)  general_output_a_sequence_delays <= reg_wdata_in;
      if (hit_gpo_b_dly)  general_output_b_sequence_delays <= reg_wdata_in;
    end
  end

  // read data is captured on the read strobe and held until the next
  // one, so the host may fetch it at any later time
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_read_in) begin
      reg_rdata_out <= next_rdata;
    end
  end

  // enable pin is synchronous; any change is an edge for every channel
  // an asynchronous source needs a two-stage synchroniser ahead of it
  assign pin_edge = (enable_pin_in != pin_q);

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= enable_pin_in;
    end
  end

  // global range selects apply to every channel alike
  assign startup_long  = configuration[STARTUP_RANGE_BIT];        // [R17]
  assign shutdown_long = configuration[SHUTDOWN_RANGE_BIT];       // [R18]

  // delay registers in channel order
  assign channel_delays[CH_REG_A] = regulator_a_sequence_delays;
  assign channel_delays[CH_REG_B] = regulator_b_sequence_delays;
  assign channel_delays[CH_GPO_A] = general_output_a_sequence_delays;
  assign channel_delays[CH_GPO_B] = general_output_b_sequence_delays;

  // the new pin level picks the range, as it picks the field below
  assign active_long = enable_pin_in ? startup_long    // [R15]
                                     : shutdown_long;  // [R16]

  // one timer per output; field is picked by the direction of the edge
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_channel
    // rising edge uses the low nibble, falling edge the high nibble
    assign channel_code[ch] = enable_pin_in             // [R6] [R8]
        ? channel_delays[ch][TURNON_FIELD_LSB +:        // [R10] [R12]
                             DELAY_FIELD_WIDTH]
        : channel_delays[ch][TURNOFF_FIELD_LSB +:       // [R7] [R9]
                             DELAY_FIELD_WIDTH];        // [R11] [R13]

    sequence_delay_channel #(
      .STEP_CYCLES (STEP_CYCLES)
    ) u_delay (
      .ref_clk_in    (ref_clk_in),
      .rst_in        (rst_in),
      .pin_level_in  (enable_pin_in),
      .pin_edge_in   (pin_edge),
      .delay_code_in (channel_code[ch]),
      .long_range_in (active_long),
      .level_out     (channel_level[ch]),
      .busy_out      (channel_busy[ch])
    );
  end

  // pin gating: the enable bit alone, or the bit and the delayed pin
  assign next_regulator_a_on =
      regulator_a_control[REG_ENABLE_BIT] &
      (~regulator_a_control[REG_PIN_GATING_BIT] |
       channel_level[CH_REG_A]);                      // [R19] [R6] [R7]
  assign next_regulator_b_on =
      regulator_b_control[REG_ENABLE_BIT] &
      (~regulator_b_control[REG_PIN_GATING_BIT] |
       channel_level[CH_REG_B]);                      // [R19] [R8] [R9]
  assign next_general_output_a =
      general_output_control[GPO_A_LEVEL_BIT] &
      (~general_output_control[GPO_A_PIN_GATING_BIT] |
       channel_level[CH_GPO_A]);                      // [R10] [R11]
  assign next_general_output_b =
      general_output_control[GPO_B_LEVEL_BIT] &
      (~general_output_control[GPO_B_PIN_GATING_BIT] |
       channel_level[CH_GPO_B]);                      // [R12] [R13]

  // both regulators share one mapping, so a code means one voltage
  assign regulator_a_target_mv =
      setpoint_to_mv(regulator_a_voltage_setpoint);   // [R4] [R2] [R3]
  assign regulator_b_target_mv =
      setpoint_to_mv(regulator_b_voltage_setpoint);   // [R5] [R2] [R3]

  // all outputs leave from flops, costing one cycle of latency
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      regulator_a_on_out   <= 1'b0;
      regulator_b_on_out   <= 1'b0;
      general_output_a_out <= 1'b0;
      general_output_b_out <= 1'b0;
    end else begin
      regulator_a_on_out   <= next_regulator_a_on;
      regulator_b_on_out   <= next_regulator_b_on;
      general_output_a_out <= next_general_output_a;
      general_output_b_out <= next_general_output_b;
    end
  end

  // setpoint copies lag the register by one cycle, codes and volts alike
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      regulator_a_setpoint_code_out <= 8'h00;
      regulator_b_setpoint_code_out <= 8'h00;
      regulator_a_target_mv_out     <= 12'h000;
      regulator_b_target_mv_out     <= 12'h000;
    end else begin
      regulator_a_setpoint_code_out <= regulator_a_voltage_setpoint;
      regulator_b_setpoint_code_out <= regulator_b_voltage_setpoint;
      regulator_a_target_mv_out     <= regulator_a_target_mv;
      regulator_b_target_mv_out     <= regulator_b_target_mv;
    end
  end

endmodule // regulator_setpoint_and_enable_sequencer

// [test/sequencer_host_model.sv]
// host model: register accesses and the enable pin, on falling edges
`timescale 1ns/1ps
module sequencer_host_model (
  input  wire logic       ref_clk_in,
  input  wire logic [7:0] rdata_in,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            write_out,
  output logic            read_out,
  output logic            pin_out
);
  // idle bus and low pin from time zero
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    write_out = 1'b0;
    read_out = 1'b0;
    pin_out = 1'b0;
  end
  // callers keep setpoint codes at 0x4C or above
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    addr_out = a;
    wdata_out = d;
    write_out = 1'b1;
    @(negedge ref_clk_in);
    write_out = 1'b0;
    wdata_out = ~d; // stale data is scrambled, not left behind
  endtask
  task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_in);
    addr_out = a;
    read_out = 1'b1;
    @(negedge ref_clk_in);
    read_out = 1'b0;
    d = rdata_in;
  endtask
  task automatic set_pin(input logic level);
    @(negedge ref_clk_in);
    pin_out = level;
  endtask
endmodule // sequencer_host_model

// [test/sequencer_chk.sv]
// port-level assertions for the setpoint and enable sequencer
`timescale 1ns/1ps
module sequencer_chk #(
  parameter int STEP_CYCLES = 4
) (
  input wire logic        ref_clk_in,
  input wire logic        rst_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic        regulator_a_on_out,
  input wire logic        regulator_b_on_out,
  input wire logic        general_output_a_out,
  input wire logic        general_output_b_out,
  input wire logic [7:0]  regulator_a_setpoint_code_out,
  input wire logic [11:0] regulator_a_target_mv_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  wire logic [7:0] code = regulator_a_setpoint_code_out;
  wire logic [11:0] mv = regulator_a_target_mv_out;
  wire logic rw_addr = reg_addr_in inside {8'h06, 8'h07, 8'h0C,
                                           8'h0D, 8'h10, 8'h11};

  AST_RESET_QUIET: assert property ($fell(rst_in) |-> !regulator_a_on_out
    && !regulator_b_on_out && !general_output_a_out
    && !general_output_b_out && reg_rdata_out == 8'h00)
    else $error("outputs not cleared by reset");
  AST_RESERVED_MV: assert property (code < 8'h4C |-> mv == 12'h000)
    else $error("reserved code gives nonzero millivolts");
  AST_FINE_MV: assert property ((code >= 8'h4C && code <= 8'h9D) |->
    mv == 12'h3E8 + 12'(code - 8'h4C) * 12'h005)
    else $error("fine range millivolts wrong");
  AST_COARSE_MV: assert property (code >= 8'h9E |->
    mv == 12'h58C + 12'(code - 8'h9E) * 12'h014)
    else $error("coarse range millivolts wrong");
  AST_READ_SETPOINT: assert property (reg_read_in && !reg_write_in
    && reg_addr_in == 8'h06 |=> reg_rdata_out == code)
    else $error("setpoint read differs from setpoint code");
  AST_WRITE_READ: assert property (reg_write_in && !reg_read_in
    && rw_addr ##1 !reg_write_in && !reg_read_in ##1 reg_read_in
    && !reg_write_in && reg_addr_in == $past(reg_addr_in, 2)
    |=> reg_rdata_out == $past(reg_wdata_in, 3))
    else $error("read back differs from written byte");
  AST_UNMAPPED_ZERO: assert property (reg_read_in && reg_addr_in >= 8'h20
    |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  AST_RDATA_HOLD: assert property (!reg_read_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");
  AST_STATUS_LEVELS: assert property (reg_read_in && reg_addr_in == 8'h1F
    |=> reg_rdata_out[3:0] == $past({general_output_b_out,
    general_output_a_out, regulator_b_on_out, regulator_a_on_out}))
    else $error("status levels differ from outputs");
endmodule // sequencer_chk

// [test/regulator_setpoint_and_enable_sequencer_bench.sv]
// self-checking bench for the setpoint and enable sequencer
`timescale 1ns/1ps
module regulator_setpoint_and_enable_sequencer_bench;
  import sequencer_pkg::*;
  localparam int STEP = 4; // short step keeps the run brief
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr, wdata, rdata, rd;
  logic wr, rdq, pin, ra, rb, ga, gb;
  logic [7:0] code_a, code_b;
  logic [11:0] mv_a, mv_b;
  logic [7:0] dly [4] = '{8'h21, 8'hF0, 8'h3F, 8'h7A};
  logic [7:0] offs [4] = '{8'h0C, 8'h0D, 8'h10, 8'h11};
  logic [7:0] rw_offs [6] = '{8'h06, 8'h07, 8'h0C, 8'h0D, 8'h10, 8'h11};
  logic [7:0] codes [4] = '{8'h4C, 8'h9D, 8'h9E, 8'hFF};
  // 0x9D sits 81 fine steps of 5 mV above the 1 V base
  logic [11:0] mvs [4] = '{12'h3E8, 12'h57D, 12'h58C, 12'hD20};
  int err_total = 0;
  int samples_checked = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  sequencer_host_model sequencer_host_model_inst (
    .ref_clk_in(ref_clk_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .write_out(wr), .read_out(rdq), .pin_out(pin));

  regulator_setpoint_and_enable_sequencer #(.STEP_CYCLES(STEP))
    regulator_setpoint_and_enable_sequencer_inst (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .enable_pin_in(pin),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr),
    .reg_read_in(rdq), .reg_rdata_out(rdata), .regulator_a_on_out(ra),
    .regulator_b_on_out(rb), .general_output_a_out(ga),
    .general_output_b_out(gb), .regulator_a_setpoint_code_out(code_a),
    .regulator_b_setpoint_code_out(code_b),
    .regulator_a_target_mv_out(mv_a), .regulator_b_target_mv_out(mv_b));

  task automatic check(input string name, input logic [11:0] exp,
                       input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    sequencer_host_model_inst.bus_write(a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    sequencer_host_model_inst.bus_read(a, rd);
    check("read", {4'h0, exp}, {4'h0, rd});
  endtask
  // cycles from the sampled pin edge until each channel reaches level
  task automatic measure(input logic level, input logic long_range);
    int got [4];
    logic [3:0] chans;
    logic [3:0] c;
    got = '{-1, -1, -1, -1};
    sequencer_host_model_inst.set_pin(level);
    for (int n = 0; n < 130; n++) begin
      @(negedge ref_clk_in);
      chans = {gb, ga, rb, ra};
      for (int i = 0; i < 4; i++) begin
        if (chans[i] === level && got[i] < 0) got[i] = n;
      end
    end
    for (int i = 0; i < 4; i++) begin
      c = level ? dly[i][3:0] : dly[i][7:4];
      check("delay", 12'(c * (long_range ? 2 * STEP : STEP) + 1),
            12'(got[i]));
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // watchdog: fires after 20000 cycles, well above what the whole sequence needs
  initial begin
    #200000;
    err_total++;
    stop_test;
  end

  initial begin
    repeat (16) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    rst_in = 1'b0;
    foreach (rw_offs[i]) rd_chk(rw_offs[i], 8'h00);
    foreach (rw_offs[i]) begin
      wr_reg(rw_offs[i], 8'h5A + 8'(i));
      rd_chk(rw_offs[i], 8'h5A + 8'(i));
    end
    wr_reg(8'h20, 8'hFF);
    rd_chk(8'h20, 8'h00);
    foreach (codes[i]) begin
      wr_reg(8'h06, codes[i]);
      wr_reg(8'h07, codes[3 - i]);
      @(negedge ref_clk_in);
      check("mv_a", mvs[i], mv_a);
      check("mv_b", mvs[3 - i], mv_b);
      check("code_a", {4'h0, codes[i]}, {4'h0, code_a});
      check("code_b", {4'h0, codes[3 - i]}, {4'h0, code_b});
    end
    rd_chk(8'h1F, 8'h00);
    // every channel gated by its enable bit and the delayed pin
    wr_reg(8'h02, 8'h03);
    wr_reg(8'h04, 8'h03);
    wr_reg(8'h12, 8'h33);
    foreach (offs[i]) wr_reg(offs[i], dly[i]);
    wr_reg(8'h13, 8'h00);
    measure(1'b1, 1'b0);
    measure(1'b0, 1'b0);
    wr_reg(8'h13, 8'h60);
    measure(1'b1, 1'b1);
    measure(1'b0, 1'b1);
    wr_reg(8'h13, 8'h20);
    measure(1'b1, 1'b0);
    measure(1'b0, 1'b1);
    // a short pulse must not leak through; timing restarts on new edge
    foreach (offs[i]) dly[i] = 8'h22;
    foreach (offs[i]) wr_reg(offs[i], dly[i]);
    sequencer_host_model_inst.set_pin(1'b1);
    rd_chk(8'h1F, 8'hF0);
    sequencer_host_model_inst.set_pin(1'b0);
    repeat (3) @(negedge ref_clk_in);
    measure(1'b1, 1'b0);
    wr_reg(8'h02, 8'h01);
    sequencer_host_model_inst.set_pin(1'b0);
    repeat (20) @(negedge ref_clk_in);
    check("ungated", 12'h001, {11'h000, ra});
    check("gated", 12'h000, {11'h000, rb});
    wr_reg(8'h02, 8'h00);
    @(negedge ref_clk_in);
    check("bit_off", 12'h000, {11'h000, ra});
    stop_test;
  end
endmodule // regulator_setpoint_and_enable_sequencer_bench

bind regulator_setpoint_and_enable_sequencer sequencer_chk #(
  .STEP_CYCLES(STEP_CYCLES)) sequencer_chk_inst (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
  .regulator_a_on_out(regulator_a_on_out),
  .regulator_b_on_out(regulator_b_on_out),
  .general_output_a_out(general_output_a_out),
  .general_output_b_out(general_output_b_out),
  .regulator_a_setpoint_code_out(regulator_a_setpoint_code_out),
  .regulator_a_target_mv_out(regulator_a_target_mv_out));
